// file: bench/pmsc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module pmsc_host_model (
    input  wire logic       clk_i,
    input  wire logic       ready_i,
    input  wire logic       settling_i,
    output logic            cmd_valid_o,
    output logic [1:0]      cmd_o,
    output logic [6:0]      cmd_addr_o
);
    // ==========================================================
    // Link clock, still between frames
    // ==========================================================
    logic link_clk = 1'b0;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = 2'h3;
        cmd_addr_o = 7'h7f;
    end
    // ==========================================================
    // Command issue
    // ==========================================================
    task automatic send(input logic [1:0] c, input logic [6:0] a, input bit pol);
        int n;
        n = 0;
        while (pol && (ready_i !== 1'b1 || settling_i !== 1'b0) && n < 99999) begin
            @(posedge clk_i);
            n++;
        end
        if (pol) repeat (18) #32 link_clk = ~link_clk;
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cmd_o <= c;
        cmd_addr_o <= a;
        @(posedge clk_i);
        cmd_valid_o <= 1'b0;
        cmd_o <= ~c;
        cmd_addr_o <= ~a;
    endtask
endmodule
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %s exp %h got %h", nm, (e), (g)); end end
module testbench;
    localparam int SET_C = 20;
    localparam int CHAN_C = 4;
    localparam int PWR_C = 30;
    localparam int START_C = 10;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    logic clk_i = 0, rst_i = 1, power_down_n_i = 1, mode_sleep_i = 0, single_shot_i = 0;
    logic burst_fast_i = 0, fast_mode_i = 0, bipolar_bus_i = 0, bidir_sense_i = 0;
    logic timeout_en_i = 0, bus_idle_timeout_i = 0, slow_pin_i = 0, pin_is_alert_one_i = 0;
    logic rise_en_i = 1, fall_en_i = 1, rise_keep_i = 0, fall_keep_i = 0, edge_clear_i = 0;
    logic por_clear_i = 0, cycle_done_i = 0;
    logic [1:0] mode_i = 2'h0;
    logic [3:0] chan_en_i = 4'hf;
    logic [6:0] own_addr_i = 7'h2a;
    logic [63:0] bus_raw_i = 64'h0, sense_raw_i = 64'h0;
    wire logic cmd_valid_i;
    wire logic [1:0] cmd_i;
    wire logic [6:0] cmd_addr_i;
    logic cmd_ack_o, cmd_nack_o, acc_clear_o, ctrl_apply_o, settling_o, sleep_o, powered_o;
    logic ready_o, por_flag_o, sample_start_o, pin_level_o, pin_rose_o, pin_fell_o, timeout_o;
    logic [1:0] rate_o;
    logic [63:0] bus_voltage_result_o, sense_voltage_result_o;
    logic [119:0] power_product_o;
    initial forever #4 clk_i = ~clk_i;
    pmsc_top #(.SETTLE_CYC_P(SET_C), .CHAN_CYC_P(CHAN_C), .START_CYC_P(START_C),
        .PWRUP_CYC_P(PWR_C))
    uut (.clk_i(clk_i), .rst_i(rst_i), .power_down_n_i(power_down_n_i),
        .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_addr_i(cmd_addr_i),
        .own_addr_i(own_addr_i), .mode_i(mode_i), .mode_sleep_i(mode_sleep_i),
        .single_shot_i(single_shot_i), .burst_fast_i(burst_fast_i), .fast_mode_i(fast_mode_i),
        .chan_en_i(chan_en_i), .bipolar_bus_i(bipolar_bus_i), .bidir_sense_i(bidir_sense_i),
        .timeout_en_i(timeout_en_i), .bus_idle_timeout_i(bus_idle_timeout_i),
        .slow_pin_i(slow_pin_i), .pin_is_alert_one_i(pin_is_alert_one_i),
        .rise_en_i(rise_en_i), .fall_en_i(fall_en_i), .rise_keep_i(rise_keep_i),
        .fall_keep_i(fall_keep_i), .edge_clear_i(edge_clear_i), .por_clear_i(por_clear_i),
        .cycle_done_i(cycle_done_i), .bus_raw_i(bus_raw_i), .sense_raw_i(sense_raw_i),
        .cmd_ack_o(cmd_ack_o), .cmd_nack_o(cmd_nack_o), .acc_clear_o(acc_clear_o),
        .ctrl_apply_o(ctrl_apply_o), .settling_o(settling_o), .sleep_o(sleep_o),
        .powered_o(powered_o), .ready_o(ready_o), .por_flag_o(por_flag_o), .rate_o(rate_o),
        .sample_start_o(sample_start_o), .pin_level_o(pin_level_o), .pin_rose_o(pin_rose_o),
        .pin_fell_o(pin_fell_o), .timeout_o(timeout_o),
        .bus_voltage_result_o(bus_voltage_result_o),
        .sense_voltage_result_o(sense_voltage_result_o), .power_product_o(power_product_o));
    pmsc_host_model host (.clk_i(clk_i), .ready_i(ready_o), .settling_i(settling_o),
        .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i), .cmd_addr_o(cmd_addr_i));
    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic print_verdict();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmd(input logic [1:0] c, input logic [6:0] a, input bit pol,
                       input logic ack, input logic nack, input logic clr);
        host.send(c, a, pol);
        #1;
        `CHK("ack", ack, cmd_ack_o)
        `CHK("nack", nack, cmd_nack_o)
        `CHK("acc_clr", clr, acc_clear_o)
        `CHK("ctrl", ack, ctrl_apply_o)
    endtask
    task automatic settle_len(input int exp);
        int n;
        n = 0;
        while (settling_o === 1'b1 && n < 500) begin
            tick(1);
            #1;
            n++;
        end
        `CHK("settle", exp, n)
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready_o !== 1'b1 && n < PWR_C + 20) begin
            tick(1);
            #1;
            n++;
        end
        `CHK("rdy_wait", 1'b1, n >= PWR_C && n <= PWR_C + 6)
    endtask
    task automatic cyc_done();
        tick(1);
        cycle_done_i <= 1'b1;
        tick(1);
        cycle_done_i <= 1'b0;
        tick(3);
        #1;
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_cmds();
        for (int c = 0; c < 3; c++) begin
            cmd(c[1:0], own_addr_i, 1, 1, 0, c != 1);
            settle_len(SET_C);
        end
        cmd(2'h2, 7'h00, 1, 1, 0, 1);
        settle_len(SET_C);
        cmd(2'h1, 7'h00, 1, 0, 0, 0);
        cmd(2'h2, own_addr_i + 7'h1, 1, 0, 0, 0);
        cmd(2'h1, own_addr_i, 1, 1, 0, 0);
        cmd(2'h0, own_addr_i, 0, 0, 1, 0);
        settle_len(SET_C - 2);
        $display("t_cmds done");
    endtask
    task automatic t_results();
        tick(1);
        bus_raw_i <= 64'h0100;
        sense_raw_i <= 64'h0010;
        cyc_done();
        cmd(2'h1, own_addr_i, 1, 1, 0, 0);
        `CHK("bus", 16'h0100, bus_voltage_result_o[15:0])
        `CHK("sense", 16'h0010, sense_voltage_result_o[15:0])
        `CHK("pwr", 30'h0000400, power_product_o[29:0])
        tick(1);
        bus_raw_i <= 64'h0200;
        cyc_done();
        `CHK("hold", 16'h0100, bus_voltage_result_o[15:0])
        bidir_sense_i <= 1'b1;
        sense_raw_i <= 64'hfff0;
        cyc_done();
        cmd(2'h0, own_addr_i, 1, 1, 0, 1);
        `CHK("pwr_s", 30'h3ffff800, power_product_o[29:0])
        `CHK("sense_s", 16'hfff0, sense_voltage_result_o[15:0])
        bipolar_bus_i <= 1'b1;
        bus_raw_i <= 64'hfffc;
        cyc_done();
        cmd(2'h1, own_addr_i, 1, 1, 0, 0);
        `CHK("pwr_b", 30'h0000010, power_product_o[29:0])
        bidir_sense_i <= 1'b0;
        bipolar_bus_i <= 1'b0;
        $display("t_results done");
    endtask
    task automatic t_burst();
        tick(1);
        burst_fast_i <= 1'b1;
        chan_en_i <= 4'h3;
        cmd(2'h1, own_addr_i, 1, 1, 0, 0);
        settle_len(2 * CHAN_C);
        `CHK("auto_slp", 1'b1, sleep_o)
        fast_mode_i <= 1'b1;
        cmd(2'h1, own_addr_i, 1, 1, 0, 0);
        settle_len(3 * CHAN_C);
        burst_fast_i <= 1'b0;
        fast_mode_i <= 1'b0;
        chan_en_i <= 4'hf;
        $display("t_burst done");
    endtask
    task automatic t_sleep();
        tick(1);
        mode_sleep_i <= 1'b1;
        timeout_en_i <= 1'b1;
        bus_idle_timeout_i <= 1'b1;
        cmd(2'h1, own_addr_i, 1, 1, 0, 0);
        tick(2);
        #1;
        `CHK("sleep", 1'b1, sleep_o)
        `CHK("tmo", 1'b1, timeout_o)
        mode_sleep_i <= 1'b0;
        cmd(2'h1, own_addr_i, 1, 1, 0, 0);
        tick(2);
        #1;
        `CHK("wake", 1'b0, sleep_o)
        bus_idle_timeout_i <= 1'b0;
        $display("t_sleep done");
    endtask
    task automatic t_slow();
        int n;
        n = 0;
        tick(1);
        slow_pin_i <= 1'b1;
        while (acc_clear_o !== 1'b1 && n < 12) begin
            tick(1);
            #1;
            n++;
            `CHK("pin_ctl", 1'b0, ctrl_apply_o)
        end
        `CHK("pin_clr", 1'b1, acc_clear_o)
        `CHK("lvl", 1'b1, pin_level_o)
        `CHK("rose", 1'b1, pin_rose_o)
        `CHK("rate0", pmsc_pkg::MODE_1024_SPS, rate_o)
        cyc_done();
        `CHK("rate8", pmsc_pkg::MODE_8_SPS, rate_o)
        edge_clear_i <= 1'b1;
        fall_keep_i <= 1'b1;
        tick(1);
        edge_clear_i <= 1'b0;
        slow_pin_i <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            tick(1);
            #1;
            `CHK("keep", 1'b0, acc_clear_o)
        end
        `CHK("fell", 1'b1, pin_fell_o)
        `CHK("rose_c", 1'b0, pin_rose_o)
        pin_is_alert_one_i <= 1'b1;
        slow_pin_i <= 1'b1;
        cyc_done();
        cyc_done();
        `CHK("alert", pmsc_pkg::MODE_1024_SPS, rate_o)
        $display("t_slow done");
    endtask
    task automatic t_power_down_n();
        tick(1);
        power_down_n_i <= 1'b0;
        tick(6);
        #1;
        `CHK("pwr_off", 1'b0, powered_o)
        `CHK("por_set", 1'b1, por_flag_o)
        power_down_n_i <= 1'b1;
        wait_ready();
        `CHK("def_rate", pmsc_pkg::MODE_1024_SPS, rate_o)
        $display("t_power_down_n done");
    endtask
    task automatic t_single();
        int n;
        n = 0;
        tick(1);
        pin_is_alert_one_i <= 1'b0;
        slow_pin_i <= 1'b0;
        single_shot_i <= 1'b1;
        tick(8);
        slow_pin_i <= 1'b1;
        while (sample_start_o !== 1'b1 && n < 30) begin
            tick(1);
            #1;
            n++;
        end
        `CHK("start", 3 + START_C, n)
        tick(1);
        #1;
        `CHK("start_end", 1'b0, sample_start_o)
        slow_pin_i <= 1'b0;
        mode_sleep_i <= 1'b1;
        cmd(2'h1, own_addr_i, 1, 1, 0, 0);
        slow_pin_i <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            tick(1);
            #1;
            `CHK("slp_start", 1'b0, sample_start_o)
        end
        mode_sleep_i <= 1'b0;
        slow_pin_i <= 1'b0;
        single_shot_i <= 1'b0;
        cmd(2'h1, own_addr_i, 1, 1, 0, 0);
        $display("t_single done");
    endtask
    // ==========================================================
    // Main sequence and timeout
    // ==========================================================
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    initial begin
        tick(5);
        rst_i <= 1'b0;
        #1;
        `CHK("por", 1'b1, por_flag_o)
        `CHK("rate", pmsc_pkg::MODE_1024_SPS, rate_o)
        cmd(2'h0, own_addr_i, 0, 0, 0, 0);
        wait_ready();
        por_clear_i <= 1'b1;
        tick(1);
        por_clear_i <= 1'b0;
        tick(2);
        #1;
        `CHK("por_clr", 1'b0, por_flag_o)
        t_cmds();
        t_results();
        t_burst();
        t_sleep();
        t_slow();
        t_single();
        t_power_down_n();
        print_verdict();
    end
endmodule
`default_nettype wire

// file: rtl/pmsc_pkg.sv
`default_nettype none
package pmsc_pkg;
    // ==========================================================
    // Commands, modes and timing
    // ==========================================================
    typedef enum logic [1:0] {
        PMSC_CMD_RESET_ACC,
        PMSC_CMD_KEEP_ACC,
        PMSC_CMD_BROADCAST
    } pmsc_cmd_e;

    localparam logic [6:0]  GENERAL_CALL_ADDR = 7'h00;
    localparam logic [1:0]  MODE_1024_SPS     = 2'h0;
    localparam logic [1:0]  MODE_256_SPS      = 2'h1;
    localparam logic [1:0]  MODE_64_SPS       = 2'h2;
    localparam logic [1:0]  MODE_8_SPS        = 2'h3;
    localparam int          CLK_MHZ           = 125;
    localparam int          SETTLE_US         = 1000;
    localparam int          CHAN_SETTLE_US    = 200;
    localparam int          START_DELAY_US    = 1000;
    localparam int          PWRUP_WAIT_MS     = 50;
    localparam int          SETTLE_CYC        = SETTLE_US * CLK_MHZ;
    localparam int          CHAN_SETTLE_CYC   = CHAN_SETTLE_US * CLK_MHZ;
    localparam int          START_DELAY_CYC   = START_DELAY_US * CLK_MHZ;
    localparam int          PWRUP_WAIT_CYC    = PWRUP_WAIT_MS * 1000 * CLK_MHZ;
    localparam int          BUS_MSB_USED      = 14;
    localparam logic        POR_FLAG_RESET    = 1'b1;
    localparam int          NUM_CHAN          = 4;
endpackage
`default_nettype wire

// file: rtl/pmsc_result_store.sv
`timescale 1ns/1ns
`default_nettype none
module pmsc_result_store (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       load_i,
    input  wire logic [pmsc_pkg::NUM_CHAN*16-1:0] bus_i,
    input  wire logic [pmsc_pkg::NUM_CHAN*16-1:0] sense_i,
    input  wire logic [pmsc_pkg::NUM_CHAN*30-1:0] power_i,
    output logic      [pmsc_pkg::NUM_CHAN*16-1:0] bus_o,
    output logic      [pmsc_pkg::NUM_CHAN*16-1:0] sense_o,
    output logic      [pmsc_pkg::NUM_CHAN*30-1:0] power_o
);
    // ==========================================================
    // Readable result copies, loaded as one block
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_o   <= '0;
            sense_o <= '0;
            power_o <= '0;
        end else if (load_i) begin
            bus_o   <= bus_i;
            sense_o <= sense_i;
            power_o <= power_i;
        end
    end
endmodule
`default_nettype wire

// file: rtl/pmsc_top.sv
`timescale 1ns/1ns
`default_nettype none
module pmsc_top #(
    parameter int SETTLE_CYC_P = pmsc_pkg::SETTLE_CYC,
    parameter int CHAN_CYC_P   = pmsc_pkg::CHAN_SETTLE_CYC,
    parameter int START_CYC_P  = pmsc_pkg::START_DELAY_CYC,
    parameter int PWRUP_CYC_P  = pmsc_pkg::PWRUP_WAIT_CYC
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 power_down_n_i,
    input  wire logic                 cmd_valid_i,
    input  wire logic [1:0]           cmd_i,
    input  wire logic [6:0]           cmd_addr_i,
    input  wire logic [6:0]           own_addr_i,
    input  wire logic [1:0]           mode_i,
    input  wire logic                 mode_sleep_i,
    input  wire logic                 single_shot_i,
    input  wire logic                 burst_fast_i,
    input  wire logic                 fast_mode_i,
    input  wire logic [3:0]           chan_en_i,
    input  wire logic                 bipolar_bus_i,
    input  wire logic                 bidir_sense_i,
    input  wire logic                 timeout_en_i,
    input  wire logic                 bus_idle_timeout_i,
    input  wire logic                 slow_pin_i,
    input  wire logic                 pin_is_alert_one_i,
    input  wire logic                 rise_en_i,
    input  wire logic                 fall_en_i,
    input  wire logic                 rise_keep_i,
    input  wire logic                 fall_keep_i,
    input  wire logic                 edge_clear_i,
    input  wire logic                 por_clear_i,
    input  wire logic                 cycle_done_i,
    input  wire logic [63:0]          bus_raw_i,
    input  wire logic [63:0]          sense_raw_i,
    output logic                      cmd_ack_o,
    output logic                      cmd_nack_o,
    output logic                      acc_clear_o,
    output logic                      ctrl_apply_o,
    output logic                      settling_o,
    output logic                      sleep_o,
    output logic                      powered_o,
    output logic                      ready_o,
    output logic                      por_flag_o,
    output logic [1:0]                rate_o,
    output logic                      sample_start_o,
    output logic                      pin_level_o,
    output logic                      pin_rose_o,
    output logic                      pin_fell_o,
    output logic                      timeout_o,
    output logic [63:0]               bus_voltage_result_o,
    output logic [63:0]               sense_voltage_result_o,
    output logic [119:0]              power_product_o
);
    // ==========================================================
    // Reset and power-down
    // ==========================================================
    logic pd_s1_q, pd_s2_q, sl_s1_q, sl_s2_q, sl_last_q;
    logic live_rst;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pd_s1_q <= 1'b0;
            pd_s2_q <= 1'b0;
            sl_s1_q <= 1'b0;
            sl_s2_q <= 1'b0;
        end else begin
            pd_s1_q <= power_down_n_i;
            pd_s2_q <= pd_s1_q;
            sl_s1_q <= slow_pin_i;
            sl_s2_q <= sl_s1_q;
        end
    end
    assign live_rst = rst_i | ~pd_s2_q;

    logic [31:0] pwr_cnt_q;
    always_ff @(posedge clk_i) begin
        if (live_rst) begin
            pwr_cnt_q <= '0;
            ready_o   <= 1'b0;
            powered_o <= 1'b0;
        end else begin
            powered_o <= 1'b1;
            if (pwr_cnt_q < PWRUP_CYC_P) begin
                pwr_cnt_q <= pwr_cnt_q + 32'h1;
            end else begin
                ready_o   <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (live_rst) begin
            por_flag_o <= pmsc_pkg::POR_FLAG_RESET;
        end else if (por_clear_i) begin
            por_flag_o <= 1'b0;
        end
    end

    // ==========================================================
    // Command decode and settling window
    // ==========================================================
    logic addr_hit, is_bcast, take_cmd, host_snap, pin_snap, pin_keep;
    logic rise, fall;
    logic [31:0] settle_q, settle_len;
    logic [2:0]  n_active;
    assign is_bcast = cmd_i == 2'(pmsc_pkg::PMSC_CMD_BROADCAST);
    assign addr_hit = (cmd_addr_i == own_addr_i) ||
                      (is_bcast && cmd_addr_i == pmsc_pkg::GENERAL_CALL_ADDR);
    assign take_cmd = cmd_valid_i && addr_hit && settle_q == 32'h0 && ready_o;
    assign host_snap = take_cmd;
    assign rise = sl_s2_q & ~sl_last_q;
    assign fall = ~sl_s2_q & sl_last_q;
    assign pin_snap = !pin_is_alert_one_i && ((rise && rise_en_i) || (fall && fall_en_i));
    assign pin_keep = rise ? rise_keep_i : fall_keep_i;
    assign n_active = 3'(chan_en_i[0]) + 3'(chan_en_i[1]) + 3'(chan_en_i[2]) + 3'(chan_en_i[3]);
    always_comb begin
        if (burst_fast_i && chan_en_i != 4'hf) begin
            settle_len = 32'(n_active) * 32'(CHAN_CYC_P);
            if (fast_mode_i) begin
                settle_len = settle_len + 32'(CHAN_CYC_P);
            end
        end else begin
            settle_len = 32'(SETTLE_CYC_P);
        end
    end

    always_ff @(posedge clk_i) begin
        if (live_rst) begin
            settle_q     <= '0;
            cmd_ack_o    <= 1'b0;
            cmd_nack_o   <= 1'b0;
            acc_clear_o  <= 1'b0;
            ctrl_apply_o <= 1'b0;
            settling_o   <= 1'b0;
        end else begin
            cmd_ack_o    <= take_cmd;
            cmd_nack_o   <= cmd_valid_i && addr_hit && !take_cmd;
            acc_clear_o  <= (host_snap && cmd_i != 2'(pmsc_pkg::PMSC_CMD_KEEP_ACC)) ||
                            (pin_snap && !pin_keep);
            ctrl_apply_o <= host_snap;
            if (host_snap || pin_snap) begin
                settle_q   <= settle_len;
                settling_o <= settle_len != 32'h0;
            end else if (settle_q != 32'h0) begin
                settle_q   <= settle_q - 32'h1;
                settling_o <= settle_q != 32'h1;
            end
        end
    end

    // ==========================================================
    // Atomic result capture
    // ==========================================================
    logic [63:0]  bus_done_q, sense_done_q;
    logic [119:0] pow_now;
    logic [119:0] pow_done_q;
    genvar g;
    generate
        for (g = 0; g < pmsc_pkg::NUM_CHAN; g++) begin : g_pow
            logic signed [16:0] sv;
            logic signed [14:0] bv;
            logic signed [31:0] pp;
            assign sv = bidir_sense_i ? {sense_raw_i[g*16+15], sense_raw_i[g*16+:16]}
                                      : {1'b0, sense_raw_i[g*16+:16]};
            assign bv = bipolar_bus_i ? {bus_raw_i[g*16+15], bus_raw_i[g*16+2+:14]}
                                      : {1'b0, bus_raw_i[g*16+2+:14]};
            assign pp = 32'(sv) * 32'(bv);
            assign pow_now[g*30+:30] = pp[29:0];
        end
    endgenerate
    always_ff @(posedge clk_i) begin
        if (live_rst) begin
            bus_done_q   <= '0;
            sense_done_q <= '0;
            pow_done_q   <= '0;
        end else if (cycle_done_i) begin
            bus_done_q   <= bus_raw_i;
            sense_done_q <= sense_raw_i;
            pow_done_q   <= pow_now;
        end
    end
    pmsc_result_store u_store (
        .clk_i   (clk_i),
        .rst_i   (live_rst),
        .load_i  (host_snap || pin_snap),
        .bus_i   (bus_done_q),
        .sense_i (sense_done_q),
        .power_i (pow_done_q),
        .bus_o   (bus_voltage_result_o),
        .sense_o (sense_voltage_result_o),
        .power_o (power_product_o)
    );

    // ==========================================================
    // Rate, sleep and slow pin
    // ==========================================================
    logic [1:0] mode_act_q;
    logic       sleep_act_q, slow_eff_q;
    logic [31:0] start_q;
    always_ff @(posedge clk_i) begin
        if (live_rst) begin
            mode_act_q  <= pmsc_pkg::MODE_1024_SPS;
            sleep_act_q <= 1'b0;
            slow_eff_q  <= 1'b0;
            rate_o      <= pmsc_pkg::MODE_1024_SPS;
            sleep_o     <= 1'b0;
            sl_last_q   <= 1'b0;
            pin_level_o <= 1'b0;
            pin_rose_o  <= 1'b0;
            pin_fell_o  <= 1'b0;
            timeout_o   <= 1'b0;
        end else begin
            sl_last_q   <= sl_s2_q;
            pin_level_o <= sl_s2_q;
            pin_rose_o  <= rise || (pin_rose_o && !edge_clear_i);
            pin_fell_o  <= fall || (pin_fell_o && !edge_clear_i);
            timeout_o   <= timeout_en_i && bus_idle_timeout_i;
            if (host_snap) begin
                mode_act_q  <= mode_i;
                sleep_act_q <= mode_sleep_i;
            end
            if (cycle_done_i) begin
                slow_eff_q <= sl_s2_q && !pin_is_alert_one_i;
            end
            rate_o  <= slow_eff_q ? pmsc_pkg::MODE_8_SPS : mode_act_q;
            sleep_o <= sleep_act_q || (!cycle_done_i &&
                       (rate_o != pmsc_pkg::MODE_1024_SPS || chan_en_i != 4'hf));
        end
    end

    always_ff @(posedge clk_i) begin
        if (live_rst) begin
            start_q        <= '0;
            sample_start_o <= 1'b0;
        end else begin
            sample_start_o <= start_q == 32'h1;
            if (rise && single_shot_i && !sleep_act_q && !pin_is_alert_one_i) begin
                start_q <= 32'(START_CYC_P);
            end else if (start_q != 32'h0) begin
                start_q <= start_q - 32'h1;
            end
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    chk_nack_window: assert property (@(posedge clk_i) disable iff (live_rst)
        (cmd_valid_i && addr_hit && settle_q != 32'h0) |=> cmd_nack_o && !cmd_ack_o)
        else $error("command in window not refused");
    chk_keep_no_clear: assert property (@(posedge clk_i) disable iff (live_rst)
        (take_cmd && cmd_i == 2'(pmsc_pkg::PMSC_CMD_KEEP_ACC) && !pin_snap) |=> !acc_clear_o)
        else $error("keep snapshot cleared accumulators");
    chk_reset_clear: assert property (@(posedge clk_i) disable iff (live_rst)
        (take_cmd && cmd_i != 2'(pmsc_pkg::PMSC_CMD_KEEP_ACC)) |=> acc_clear_o)
        else $error("reset snapshot did not clear");
    chk_bcast_gc: assert property (@(posedge clk_i) disable iff (live_rst)
        (cmd_valid_i && is_bcast && cmd_addr_i == 7'h00 && settle_q == 0 && ready_o)
        |=> cmd_ack_o) else $error("general call broadcast not taken");
    chk_other_addr: assert property (@(posedge clk_i) disable iff (live_rst)
        (cmd_valid_i && cmd_addr_i != own_addr_i && cmd_addr_i != 7'h00) |=> !cmd_ack_o)
        else $error("foreign address taken");
    chk_alert_rate: assert property (@(posedge clk_i) disable iff (live_rst)
        pin_is_alert_one_i && $past(pin_is_alert_one_i) && cycle_done_i ##1 1 |=> !slow_eff_q)
        else $error("alert pin changed rate");
    chk_pin_limited: assert property (@(posedge clk_i) disable iff (live_rst)
        (pin_snap && !host_snap) |=> !ctrl_apply_o ##1 settling_o)
        else $error("pin snapshot applied control");
    chk_hold_result: assert property (@(posedge clk_i) disable iff (live_rst)
        (!host_snap && !pin_snap) |=> $stable(bus_voltage_result_o))
        else $error("readout moved without snapshot");
    chk_por_set: assert property (@(posedge clk_i)
        $fell(live_rst) |-> por_flag_o)
        else $error("power-on flag not set");
endmodule
`default_nettype wire
